// [guard_pkg.sv]
// Shared constants, register map and carrier types of the chip timeout guard.
// Assumes one clock domain (the oscillator clock) and a 32-bit AXI4-Lite bus.
package guard_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W     = 18;
  localparam int PRESCALE_W = 16;
  localparam int COUNT_W    = 12;
  localparam int CTRL_W     = 2;
  localparam int IRQ_W      = 2;

  // ----------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_CONTROL    = 16'hf020;
  localparam logic [15:0] IDX_PRESCALE   = 16'hf021;
  localparam logic [15:0] IDX_DIVIDER    = 16'hf022;
  localparam logic [15:0] IDX_COUNTDOWN  = 16'hf023;
  localparam logic [15:0] IDX_HISTORY    = 16'hf024;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hf025;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'hf026;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_COUNT_EN_BIT = 0;
  localparam int CTRL_ARM_BIT      = 1;
  localparam int HIST_TRIG_BIT     = 0;
  localparam int IRQ_TIMEOUT_BIT   = 0;
  localparam int IRQ_WRAP_BIT      = 1;

  // ----------------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------------
  localparam logic [CTRL_W-1:0]     CONTROL_RST  = 2'h0;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 16'h0000;
  localparam logic [PRESCALE_W-1:0] DIVIDER_RST  = 16'hffff;
  localparam logic [COUNT_W-1:0]    COUNT_RST    = 12'hfff;
  localparam logic                  HISTORY_RST  = 1'b0;
  localparam logic [IRQ_W-1:0]      IRQ_RST      = 2'h0;
  localparam logic [1:0]            RESP_OKAY    = 2'h0;
  localparam logic [1:0]            RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [15:0] index;
    logic [31:0] data;
    logic [3:0]  strb;
  } reg_write_s;

  // Mapped register test, shared by the write and read paths
  function automatic logic reg_hit(input logic [15:0] index);
    logic hit;
    hit = 1'b0;
    if (index == IDX_CONTROL) hit = 1'b1;
    else if (index == IDX_PRESCALE) hit = 1'b1;
    else if (index == IDX_DIVIDER) hit = 1'b1;
    else if (index == IDX_COUNTDOWN) hit = 1'b1;
    else if (index == IDX_HISTORY) hit = 1'b1;
    else if (index == IDX_IRQ_STATUS) hit = 1'b1;
    else if (index == IDX_IRQ_MASK) hit = 1'b1;
    return hit;
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

endpackage

// [guard_countdown.sv]
// Prescaler and countdown of the chip timeout guard.
// Assumes aclk is the oscillator clock and rst_n a synchronous active-low reset.
`timescale 1ns/1ps
module guard_countdown (
  input  wire logic                                aclk,
  input  wire logic                                rst_n,
  input  wire logic                                count_en,
  input  wire logic [guard_pkg::PRESCALE_W-1:0]    divider,
  input  wire logic                                load,
  input  wire logic [guard_pkg::COUNT_W-1:0]       load_value,
  output logic      [guard_pkg::PRESCALE_W-1:0]    prescale,
  output logic      [guard_pkg::COUNT_W-1:0]       count,
  output logic                                     wrap_tick,
  output logic                                     zero_hit
);

  typedef struct packed {
    logic [guard_pkg::PRESCALE_W-1:0] prescale;
    logic [guard_pkg::COUNT_W-1:0]    count;
    logic                             wrap_tick;
    logic                             zero_hit;
  } core_s;

  localparam core_s CORE_RST = '{prescale:  guard_pkg::PRESCALE_RST,
                                 count:     guard_pkg::COUNT_RST,
                                 wrap_tick: 1'b0,
                                 zero_hit:  1'b0};

  core_s st;
  core_s next_st;

  always_comb begin
    next_st           = st;
    next_st.wrap_tick = 1'b0;
    next_st.zero_hit  = 1'b0;
    if (count_en) begin
      // Compare with >= so a divider lowered below the prescaler wraps at once
      if (st.prescale >= divider) begin
        next_st.prescale  = guard_pkg::PRESCALE_RST;
        next_st.wrap_tick = 1'b1;
        if (st.count != '0) begin
          next_st.count = st.count - 12'h001;
          // Only the step onto zero fires; zero then holds
          next_st.zero_hit = (st.count == 12'h001);
        end
      end else begin
        next_st.prescale = st.prescale + 16'h0001;
      end
    end
    if (load) begin
      next_st.count    = load_value;
      next_st.zero_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      st <= CORE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prescale  = st.prescale;
  assign count     = st.count;
  assign wrap_tick = st.wrap_tick;
  assign zero_hit  = st.zero_hit;

endmodule

// [guard_axil_slave.sv]
// AXI4-Lite slave front end: one write and one read in flight at a time.
// Assumes the owner supplies read data for araddr combinationally.
`timescale 1ns/1ps
module guard_axil_slave (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [guard_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [guard_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [31:0]                   rd_word,
  output guard_pkg::reg_write_s              wr
);

  typedef enum logic [1:0] {PH_IDLE = 2'b01, PH_RESP = 2'b10} phase_e;

  typedef struct packed {
    phase_e                wph;
    logic                  aw_held;
    logic                  w_held;
    logic [15:0]           aw_idx;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    phase_e                rph;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    guard_pkg::reg_write_s wr;
  } slave_s;

  localparam slave_s SLAVE_RST = '{wph: PH_IDLE, rph: PH_IDLE, default: '0};

  slave_s st;
  slave_s next_st;

  always_comb begin
    next_st          = st;
    next_st.wr.valid = 1'b0;
    // ------------------------------------------------------------------
    // Write: address and data taken in either order
    // ------------------------------------------------------------------
    case (st.wph)
      PH_IDLE: begin
        if (s_axi_awvalid && st.awready) begin
          next_st.aw_held = 1'b1;
          next_st.aw_idx  = s_axi_awaddr[17:2];
        end
        if (s_axi_wvalid && st.wready) begin
          next_st.w_held = 1'b1;
          next_st.w_data = s_axi_wdata;
          next_st.w_strb = s_axi_wstrb;
        end
        if (next_st.aw_held && next_st.w_held) begin
          next_st.wph      = PH_RESP;
          next_st.aw_held  = 1'b0;
          next_st.w_held   = 1'b0;
          next_st.bvalid   = 1'b1;
          next_st.wr.valid = guard_pkg::reg_hit(next_st.aw_idx);
          next_st.wr.index = next_st.aw_idx;
          next_st.wr.data  = next_st.w_data;
          next_st.wr.strb  = next_st.w_strb;
          next_st.bresp    = guard_pkg::reg_hit(next_st.aw_idx) ?
                             guard_pkg::RESP_OKAY : guard_pkg::RESP_SLVERR;
        end
      end
      PH_RESP: begin
        if (s_axi_bready) begin
          next_st.bvalid = 1'b0;
          next_st.wph    = PH_IDLE;
        end
      end
      default: next_st.wph = PH_IDLE;
    endcase
    next_st.awready = (next_st.wph == PH_IDLE) && !next_st.aw_held;
    next_st.wready  = (next_st.wph == PH_IDLE) && !next_st.w_held;
    // ------------------------------------------------------------------
    // Read
    // ------------------------------------------------------------------
    case (st.rph)
      PH_IDLE: begin
        if (s_axi_arvalid && st.arready) begin
          next_st.rph    = PH_RESP;
          next_st.rvalid = 1'b1;
          next_st.rdata  = rd_word;
          next_st.rresp  = guard_pkg::reg_hit(s_axi_araddr[17:2]) ?
                           guard_pkg::RESP_OKAY : guard_pkg::RESP_SLVERR;
        end
      end
      PH_RESP: begin
        if (s_axi_rready) begin
          next_st.rvalid = 1'b0;
          next_st.rph    = PH_IDLE;
        end
      end
      default: next_st.rph = PH_IDLE;
    endcase
    next_st.arready = (next_st.rph == PH_IDLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= SLAVE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign wr            = st.wr;

endmodule

// [chip_timeout_reset_guard.sv]
// Chip timeout guard: countdown that resets the chip unless rewritten.
// Assumes aclk is the oscillator clock; aresetn and por_n are synchronous
// to it; chip_reset is stretched and fed back to aresetn by the system.
//
// Overview of operation
// - After reset count enable and reset arm are both zero.
// - Control bit 0 starts and stops the countdown logic.
// - Control bit 1 arms the chip reset on reaching zero.
// - Counting may run with the arm clear, for debug only.
// - Prescaler advances each clock, wraps to zero, then decrements countdown.
// - Current prescaler value is readable any time, read only.
// - Divider is read-write, resets to all ones, ratio is value plus one.
// - Countdown resets to all ones, decrements once per prescaler wrap.
// - Countdown reaching zero while armed issues a chip-wide reset.
// - A write to the countdown loads a new starting point.
// - History bit 0 reads one once a timeout has triggered.
// - History bit survives every reset except power-on reset.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module chip_timeout_reset_guard (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          por_n,
  input  wire logic [guard_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [guard_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic                               chip_reset,
  output logic                               timeout_seen,
  output logic                               irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [guard_pkg::CTRL_W-1:0]     control;
    logic [guard_pkg::PRESCALE_W-1:0] divider;
    logic                             history;
    logic [guard_pkg::IRQ_W-1:0]      irq_status;
    logic [guard_pkg::IRQ_W-1:0]      irq_mask;
    logic                             chip_reset;
    logic                             irq;
  } guard_s;

  localparam guard_s GUARD_RST = '{control:    guard_pkg::CONTROL_RST,
                                   divider:    guard_pkg::DIVIDER_RST,
                                   history:    guard_pkg::HISTORY_RST,
                                   irq_status: guard_pkg::IRQ_RST,
                                   irq_mask:   guard_pkg::IRQ_RST,
                                   chip_reset: 1'b0,
                                   irq:        1'b0};

  guard_s st;
  guard_s next_st;

  // ----------------------------------------------------------------------
  // Interconnect
  // ----------------------------------------------------------------------
  guard_pkg::reg_write_s                wr;
  logic [31:0]                          rd_word;
  logic [15:0]                          rd_idx;
  logic [guard_pkg::PRESCALE_W-1:0]     prescale;
  logic [guard_pkg::COUNT_W-1:0]        count;
  logic                                 wrap_tick;
  logic                                 zero_hit;
  logic                                 core_rst_n;
  logic                                 count_load;
  logic [31:0]                          count_word;
  logic [31:0]                          ctrl_word;
  logic [31:0]                          div_word;
  logic [31:0]                          mask_word;
  logic [guard_pkg::IRQ_W-1:0]          irq_set;
  logic [guard_pkg::IRQ_W-1:0]          irq_clr;
  logic                                 fire;

  // Counters follow both the system reset and the power-on reset
  assign core_rst_n = aresetn && por_n;

  // ----------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------
  guard_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (core_rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rd_word       (rd_word),
    .wr            (wr)
  );

  // ----------------------------------------------------------------------
  // Prescaler and countdown
  // ----------------------------------------------------------------------
  guard_countdown u_core (
    .aclk       (aclk),
    .rst_n      (core_rst_n),
    .count_en   (st.control[guard_pkg::CTRL_COUNT_EN_BIT]),
    .divider    (st.divider),
    .load       (count_load),
    .load_value (count_word[guard_pkg::COUNT_W-1:0]),
    .prescale   (prescale),
    .count      (count),
    .wrap_tick  (wrap_tick),
    .zero_hit   (zero_hit)
  );

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  always_comb begin
    ctrl_word  = guard_pkg::byte_merge({30'h0, st.control}, wr.data, wr.strb);
    div_word   = guard_pkg::byte_merge({16'h0, st.divider}, wr.data, wr.strb);
    count_word = guard_pkg::byte_merge({20'h0, count}, wr.data, wr.strb);
    mask_word  = guard_pkg::byte_merge({30'h0, st.irq_mask}, wr.data, wr.strb);
    count_load = 1'b0;
    irq_clr    = '0;
    if (wr.valid && wr.index == guard_pkg::IDX_COUNTDOWN) begin
      count_load = 1'b1;
    end else if (wr.valid && wr.index == guard_pkg::IDX_IRQ_STATUS) begin
      // Write one to clear, low byte only
      irq_clr = wr.strb[0] ? wr.data[guard_pkg::IRQ_W-1:0] : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Timeout action and events
  // ----------------------------------------------------------------------
  // Zero reached while armed; disarmed runs only raise the event
  assign fire = zero_hit && st.control[guard_pkg::CTRL_ARM_BIT];

  always_comb begin
    irq_set                             = '0;
    irq_set[guard_pkg::IRQ_TIMEOUT_BIT] = zero_hit;
    irq_set[guard_pkg::IRQ_WRAP_BIT]    = wrap_tick;
  end

  // ----------------------------------------------------------------------
  // Register file and outputs
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (wr.valid && wr.index == guard_pkg::IDX_CONTROL) begin
      next_st.control = ctrl_word[guard_pkg::CTRL_W-1:0];
    end else if (wr.valid && wr.index == guard_pkg::IDX_DIVIDER) begin
      next_st.divider = div_word[guard_pkg::PRESCALE_W-1:0];
    end else if (wr.valid && wr.index == guard_pkg::IDX_IRQ_MASK) begin
      next_st.irq_mask = mask_word[guard_pkg::IRQ_W-1:0];
    end
    // A new event beats a clear arriving in the same cycle
    next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;
    next_st.irq        = |(next_st.irq_status & next_st.irq_mask);
    // One-cycle request; the system stretches it into the chip reset
    next_st.chip_reset = fire;
    if (fire) begin
      next_st.history = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!por_n) begin
      st <= GUARD_RST;
    end else if (!aresetn) begin
      st         <= GUARD_RST;
      // History alone rides through the system reset
      st.history <= st.history;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux, fed straight from araddr
  // ----------------------------------------------------------------------
  assign rd_idx = s_axi_araddr[17:2];

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_idx == guard_pkg::IDX_CONTROL) begin
      rd_word[guard_pkg::CTRL_W-1:0] = st.control;
    end else if (rd_idx == guard_pkg::IDX_PRESCALE) begin
      rd_word[guard_pkg::PRESCALE_W-1:0] = prescale;
    end else if (rd_idx == guard_pkg::IDX_DIVIDER) begin
      rd_word[guard_pkg::PRESCALE_W-1:0] = st.divider;
    end else if (rd_idx == guard_pkg::IDX_COUNTDOWN) begin
      rd_word[guard_pkg::COUNT_W-1:0] = count;
    end else if (rd_idx == guard_pkg::IDX_HISTORY) begin
      rd_word[guard_pkg::HIST_TRIG_BIT] = st.history;
    end else if (rd_idx == guard_pkg::IDX_IRQ_STATUS) begin
      rd_word[guard_pkg::IRQ_W-1:0] = st.irq_status;
    end else if (rd_idx == guard_pkg::IDX_IRQ_MASK) begin
      rd_word[guard_pkg::IRQ_W-1:0] = st.irq_mask;
    end
  end

  assign chip_reset   = st.chip_reset;
  assign timeout_seen = st.history;
  assign irq          = st.irq;

endmodule

// [guard_chk.sv]
// Port checker of the chip timeout guard.
// Assumes binding into chip_timeout_reset_guard, one clock domain.
`timescale 1ns/1ps
module guard_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic chip_reset,
  input wire logic timeout_seen
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !por_n);
  // --------------------------------------------
  // Properties
  // --------------------------------------------
  AST_PULSE: assert property (chip_reset |=> !chip_reset [*8])
    else $error("chip reset longer than one cycle");
  AST_SEEN: assert property (chip_reset |=> timeout_seen)
    else $error("history not set by chip reset");
  // History outlives the system reset, so only por_n disables this
  AST_KEEP: assert property (disable iff (!por_n) timeout_seen |=> timeout_seen)
    else $error("history lost without power-on reset");
  AST_POR: assert property (disable iff (1'b0) !por_n |=> !timeout_seen)
    else $error("history kept through power-on reset");
  AST_QUIET: assert property ($rose(aresetn) |-> !chip_reset [*8])
    else $error("chip reset right after reset");
  AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
endmodule

bind chip_timeout_reset_guard guard_chk chk (.aclk, .aresetn, .por_n, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
  .chip_reset, .timeout_seen);

// [chip_timeout_reset_guard_bench.sv]
// Self-checking bench of the chip timeout guard.
// Assumes the bench plays the system: it loops no reset back itself.
`timescale 1ns/1ps
module chip_timeout_reset_guard_bench;
  localparam logic [15:0] C = guard_pkg::IDX_CONTROL, P = guard_pkg::IDX_PRESCALE;
  localparam logic [15:0] D = guard_pkg::IDX_DIVIDER, N = guard_pkg::IDX_COUNTDOWN;
  localparam logic [15:0] H = guard_pkg::IDX_HISTORY, S = guard_pkg::IDX_IRQ_STATUS;
  localparam logic [15:0] M = guard_pkg::IDX_IRQ_MASK, U = 16'hf027;
  localparam logic [1:0]  OK = guard_pkg::RESP_OKAY, ER = guard_pkg::RESP_SLVERR;
  logic aclk = 0, aresetn = 0, por_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [17:0] aw = '0, ar = '0;
  logic [31:0] wd = '0, lf = 32'h37e9db47, d;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        awr, wrd, bv, arr, rv, chip_reset, timeout_seen, irq;
  int          fails = 0, check_count = 0, pulses = 0, i;
  chip_timeout_reset_guard DUT (.aclk, .aresetn, .por_n, .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .chip_reset, .timeout_seen, .irq);
  initial forever #50 aclk = ~aclk;
  // Pulses are counted at the falling edge, clear of the launch edge
  always @(negedge aclk) pulses += (chip_reset === 1'b1);
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // --------------------------------------------
  // Tasks
  // --------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [15:0] x, input logic [31:0] v, input logic [1:0] e);
    logic ta, tw;
    @(posedge aclk);
    {aw, wd, awv, wv, br} <= {x, 2'h0, v, 3'h7};
    repeat (40) begin
      @(negedge aclk);
      {ta, tw} = {awr, wrd};
      if (bv) begin
        chk("bresp", e, bresp);
        @(posedge aclk);
        br <= 0;
        return;
      end
      @(posedge aclk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
    fails++;
    wrap_up;
  endtask
  task automatic rd(input logic [15:0] x, input logic [1:0] e, output logic [31:0] q);
    logic ta;
    @(posedge aclk);
    {ar, arv, rr} <= {x, 2'h0, 2'h3};
    repeat (40) begin
      @(negedge aclk);
      ta = arr;
      if (rv) begin
        q = rdata;
        chk("rresp", e, rresp);
        @(posedge aclk);
        rr <= 0;
        return;
      end
      @(posedge aclk);
      if (ta) arv <= 0;
    end
    fails++;
    wrap_up;
  endtask
  task automatic rc(input string nm, input logic [15:0] x, input logic [31:0] e);
    rd(x, OK, d);
    chk(nm, e, d);
  endtask
  task automatic rst(input logic p);
    aresetn <= 0;
    por_n <= !p;
    repeat (12) @(posedge aclk);
    {aresetn, por_n} <= 2'h3;
  endtask
  // --------------------------------------------
  // Sequence
  // --------------------------------------------
  initial begin
    rst(1);
    rc("control", C, 0);
    rc("divider", D, 32'hffff);
    rc("countdown", N, 32'hfff);
    rc("history", H, 0);
    wr(P, 32'h1234, OK);
    rc("prescale", P, 0);
    rd(U, ER, d);
    chk("unmapped", 0, d);
    wr(U, lf, ER);
    for (i = 0; i < 4; i++) begin
      lf = nx(lf);
      wr(D, lf, OK);
      rc("divider", D, lf & 32'hffff);
      wr(N, lf, OK);
      rc("countdown", N, lf & 32'hfff);
    end
    // Counting without arm: zero is reached, no chip reset
    wr(D, 3, OK);
    wr(N, 2, OK);
    wr(M, 1, OK);
    wr(C, 1, OK);
    for (i = 0; i < 200 && irq !== 1'b1; i++) @(negedge aclk);
    if (irq !== 1'b1) begin
      fails++;
      wrap_up;
    end
    // Two wraps of divider plus one, one edge to land control, one for irq
    chk("zero cycles", (3 + 1) * 2 + 2, i);
    rc("countdown", N, 0);
    chk("pulses", 0, pulses);
    wr(S, 1, OK);
    // Clear lands on the return edge; look once it has settled
    @(negedge aclk);
    chk("irq", 0, irq);
    wr(M, 0, OK);
    // Armed crossing with the interrupt masked
    wr(N, 2, OK);
    wr(C, 3, OK);
    for (i = 0; i < 200 && pulses < 1; i++) @(negedge aclk);
    rc("countdown", N, 0);
    chk("pulses", 1, pulses);
    chk("seen", 1, timeout_seen);
    chk("irq", 0, irq);
    // Armed, rewritten faster than one wrap per load: never reaches zero
    for (i = 0; i < 6; i++) wr(N, 2, OK);
    chk("pulses", 1, pulses);
    rst(0);
    rc("history", H, 1);
    rc("control", C, 0);
    rst(1);
    rc("history", H, 0);
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    wrap_up;
  end
endmodule
